// ---- logic/ssp_defines.vh ----
// Summary of operation
// - buffer-empty sets on reset, tx disable, load
// - buffer-full clears on reset, armed write, read
// - buffer-full sets only on clean received character
// - errors or rx disable leave buffer untouched
// - char while full: overrun, new one dropped
// - any error flag halts rx; in sync mode it halts tx too
// - rx disable keeps error flags and mp bit
// - error flags clear on reset or armed write
// - async stop bit zero gives framing error
// - frame/parity error stores char, no full flag
// - parity flag on ones count mismatch
// - tx end clears on armed write or tx write
// - tx end sets on reset, disable, empty at end
// - received mp bit captured, read only
// - mp transfer bit sent only async mp format
// - port resets only at power-on, top nibble zero
// - clock pin select drives clock data bit out
// - clock data bit reads clock pin level
// - break select drives break data on tx pin
// - port bit 0 reads receive pin level
// - divisor resets to 0xff, one generator here
// - bit rate from prescale, divisor, 32 or 4
// - divisor 0..255, prescale code n 0..3
// - prescale divides by 1, 4, 16, 64
// - flags take only written 0 after read as 1
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// register byte offsets
`define SSP_OFS_STATUS   8'h00
`define SSP_OFS_PORT     8'h04
`define SSP_OFS_BITRATE  8'h08
`define SSP_OFS_CONTROL  8'h0c
`define SSP_OFS_TXDATA   8'h10
`define SSP_OFS_RXDATA   8'h14
// status bit positions
`define SSP_ST_EMPTY     7
`define SSP_ST_FULL      6
`define SSP_ST_OVER      5
`define SSP_ST_FRM       4
`define SSP_ST_PER       3
`define SSP_ST_END       2
`define SSP_ST_RXMP      1
`define SSP_ST_TXMP      0
// port bit positions
`define SSP_PT_CKSEL     3
`define SSP_PT_CKDAT     2
`define SSP_PT_BRKSEL    1
`define SSP_PT_BRKDAT    0
// control bit positions
`define SSP_CT_TXEN      0
`define SSP_CT_RXEN      1
`define SSP_CT_SYNC      2
`define SSP_CT_MPFMT     3
`define SSP_CT_PAREN     4
`define SSP_CT_PARODD    5
`define SSP_CT_CKS_LO    6
`define SSP_CT_CKS_HI    7
`define SSP_CT_CKE_LO    8
`define SSP_CT_CKE_HI    9
`define SSP_CT_WIDTH     10
// reset values
`define SSP_PORT_RST     4'h0
`define SSP_BITRATE_RST  8'hff
`define SSP_CTRL_RST     10'h000
// prescale masks for divide by 1, 4, 16, 64
`define SSP_PRE_M0       6'h00
`define SSP_PRE_M1       6'h03
`define SSP_PRE_M2       6'h0f
`define SSP_PRE_M3       6'h3f
// brg ticks per bit: 64/2 async, 8/2 sync
`define SSP_BIT_LAST_AS  5'h1f
`define SSP_BIT_LAST_SY  5'h03
// axi responses
`define SSP_RESP_OKAY    2'h0
`define SSP_RESP_SLVERR  2'h2
`endif

// ---- logic/ssp_serial_status_port_baud.v ----
// Chosen here: the AXI4-Lite register port and the register addresses.
`include "ssp_defines.vh"
`default_nettype none
module ssp_serial_status_port_baud #(
  parameter ADDR_W = 8
) (
  input  wire              core_clk_i,
  input  wire              sys_rst_i,
  input  wire              manual_rst_i,
  input  wire              standby_i,
  input  wire              module_standby_i,
  // axi4-lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  output wire [1:0]        s_axi_bresp_o,
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  // shift engine side
  input  wire              tx_load_i,
  input  wire              tx_last_bit_i,
  input  wire              tx_serial_i,
  input  wire              rx_done_i,
  input  wire [7:0]        rx_char_i,
  input  wire              rx_parity_bit_i,
  input  wire              rx_stop_bit_i,
  input  wire              rx_mp_bit_i,
  input  wire              eng_sck_i,
  input  wire              eng_sck_oe_i,
  output reg  [7:0]        tx_data_o,
  output reg               tx_data_valid_o,
  output wire              tx_mp_bit_o,
  output wire              tx_enable_o,
  output wire              rx_enable_o,
  output wire              sync_mode_o,
  output wire              parity_en_o,
  output wire              parity_odd_o,
  output wire [1:0]        clock_source_o,
  output reg               brg_tick_o,
  output reg               bit_tick_o,
  // pins
  input  wire              rxd_i,
  input  wire              sck_i,
  output reg               txd_o,
  output reg               sck_o,
  output reg               sck_oe_o
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg                    txe_reg;
  reg                    rxf_reg;
  reg                    ovr_reg;
  reg                    frm_reg;
  reg                    per_reg;
  reg                    txend_reg;
  reg                    rxmp_reg;
  reg                    txmp_reg;
  reg  [4:0]             arm_reg;
  reg  [3:0]             port_reg;
  reg  [7:0]             bitrate_reg;
  reg  [`SSP_CT_WIDTH-1:0] ctrl_reg;
  reg  [7:0]             rx_data_reg;
  reg                    aw_full_reg;
  reg                    w_full_reg;
  reg  [ADDR_W-1:0]      aw_addr_reg;
  reg  [31:0]            w_data_reg;
  reg  [3:0]             w_strb_reg;
  reg                    bvalid_reg;
  reg  [1:0]             bresp_reg;
  reg                    rvalid_reg;
  reg  [31:0]            rdata_reg;
  reg  [1:0]             rresp_reg;
  reg  [5:0]             pre_cnt_reg;
  reg  [7:0]             brg_cnt_reg;
  reg  [4:0]             bit_cnt_reg;

  wire soft_rst = sys_rst_i | manual_rst_i | standby_i | module_standby_i;

  // ------------------------------------------------------------
  // axi4-lite handshakes
  // ------------------------------------------------------------
  assign s_axi_awready_o = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready_o  = ~w_full_reg & ~bvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = ~rvalid_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
  wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
  wire wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire lane0   = w_strb_reg[0];
  wire [7:0] wbyte = w_data_reg[7:0];
  wire [7:0] waddr = aw_addr_reg[7:0];
  wire [7:0] raddr = s_axi_araddr_i[7:0];

  wire wr_status = wr_fire & lane0 & (waddr == `SSP_OFS_STATUS);
  wire wr_port   = wr_fire & lane0 & (waddr == `SSP_OFS_PORT);
  wire wr_brr    = wr_fire & lane0 & (waddr == `SSP_OFS_BITRATE);
  wire wr_ctrl   = wr_fire & (waddr == `SSP_OFS_CONTROL);
  wire wr_tdr    = wr_fire & lane0 & (waddr == `SSP_OFS_TXDATA);
  wire rd_status = ar_take & (raddr == `SSP_OFS_STATUS);
  wire rd_rdr    = ar_take & (raddr == `SSP_OFS_RXDATA);

  wire wr_known = (waddr == `SSP_OFS_STATUS) | (waddr == `SSP_OFS_PORT) |
                  (waddr == `SSP_OFS_BITRATE) |
                  (waddr == `SSP_OFS_CONTROL) |
                  (waddr == `SSP_OFS_TXDATA) | (waddr == `SSP_OFS_RXDATA);

  // write channel capture and response
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `SSP_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (bvalid_reg & s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [7:0] status_rd = {txe_reg, rxf_reg, ovr_reg, frm_reg,
                          per_reg, txend_reg, rxmp_reg, txmp_reg};
  // pin levels replace stored data bits on read
  wire [7:0] port_rd = {4'h0, port_reg[`SSP_PT_CKSEL], sck_i,
                        port_reg[`SSP_PT_BRKSEL], rxd_i};
  reg  [31:0] rd_mux;
  reg  [1:0]  rd_resp;

  always @* begin
    rd_mux  = 32'h0000_0000;
    rd_resp = `SSP_RESP_OKAY;
    case (raddr)
      `SSP_OFS_STATUS:  rd_mux[7:0] = status_rd;
      `SSP_OFS_PORT:    rd_mux[7:0] = port_rd;
      `SSP_OFS_BITRATE: rd_mux[7:0] = bitrate_reg;
      `SSP_OFS_CONTROL: rd_mux[`SSP_CT_WIDTH-1:0] = ctrl_reg;
      `SSP_OFS_TXDATA:  rd_mux[7:0] = tx_data_o;
      `SSP_OFS_RXDATA:  rd_mux[7:0] = rx_data_reg;
      default:          rd_resp = `SSP_RESP_SLVERR;
    endcase
  end

  // read channel
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `SSP_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_resp;
    end else if (rvalid_reg & s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // control and port registers
  // ------------------------------------------------------------
  wire tx_en   = ctrl_reg[`SSP_CT_TXEN];
  wire rx_en   = ctrl_reg[`SSP_CT_RXEN];
  wire sync    = ctrl_reg[`SSP_CT_SYNC];
  wire mp_fmt  = ctrl_reg[`SSP_CT_MPFMT];
  wire par_en  = ctrl_reg[`SSP_CT_PAREN];
  wire par_odd = ctrl_reg[`SSP_CT_PARODD];
  wire [1:0] cks = {ctrl_reg[`SSP_CT_CKS_HI], ctrl_reg[`SSP_CT_CKS_LO]};

  always @(posedge core_clk_i) begin
    if (soft_rst) begin
      ctrl_reg <= `SSP_CTRL_RST;
    end else if (wr_ctrl) begin
      if (w_strb_reg[0])
        ctrl_reg[7:0] <= wbyte;
      if (w_strb_reg[1])
        ctrl_reg[`SSP_CT_WIDTH-1:8] <= w_data_reg[`SSP_CT_WIDTH-1:8];
    end
  end

  // port survives manual reset and standby
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      port_reg <= `SSP_PORT_RST;
    end else if (wr_port) begin
      port_reg <= wbyte[3:0];
    end
  end

  // divisor
  always @(posedge core_clk_i) begin
    if (soft_rst) begin
      bitrate_reg <= `SSP_BITRATE_RST;
    end else if (wr_brr) begin
      bitrate_reg <= wbyte;
    end
  end

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  wire err_any = ovr_reg | frm_reg | per_reg;
  wire rx_take = rx_done_i & rx_en & ~err_any;
  wire fe_now  = ~sync & ~rx_stop_bit_i;
  wire pe_now  = ~sync & par_en &
                 ((^{rx_char_i, rx_parity_bit_i}) != par_odd);
  wire rx_over = rx_take & rxf_reg;
  wire rx_store = rx_take & ~rxf_reg;
  wire rx_good = rx_store & ~fe_now & ~pe_now;

  // receive buffer written only when it is free
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_data_reg <= 8'h00;
    end else if (rx_store) begin
      rx_data_reg <= rx_char_i;
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  // a written 0 clears only a flag armed by a read as 1
  wire [4:0] flags = {txe_reg, rxf_reg, ovr_reg, frm_reg, per_reg};
  wire [4:0] clr_w = {5{wr_status}} & ~wbyte[7:3] & arm_reg;
  wire clr_txe  = clr_w[4];
  wire clr_rxf  = clr_w[3];
  wire clr_ovr  = clr_w[2];
  wire clr_frm  = clr_w[1];
  wire clr_per  = clr_w[0];

  // arm bits follow reads of set flags
  always @(posedge core_clk_i) begin
    if (soft_rst) begin
      arm_reg <= 5'h00;
    end else begin
      arm_reg <= flags & (arm_reg | ({5{rd_status}} & flags));
    end
  end

  // flags, set wins over clear
  always @(posedge core_clk_i) begin
    if (soft_rst) begin
      txe_reg   <= 1'b1;
      rxf_reg   <= 1'b0;
      ovr_reg   <= 1'b0;
      frm_reg   <= 1'b0;
      per_reg   <= 1'b0;
      txend_reg <= 1'b1;
      rxmp_reg  <= 1'b0;
      txmp_reg  <= 1'b0;
    end else begin
      if (~tx_en | tx_load_i)
        txe_reg <= 1'b1;
      else if (clr_txe | wr_tdr)
        txe_reg <= 1'b0;
      if (rx_good)
        rxf_reg <= 1'b1;
      else if (clr_rxf | rd_rdr)
        rxf_reg <= 1'b0;
      if (rx_over)
        ovr_reg <= 1'b1;
      else if (clr_ovr)
        ovr_reg <= 1'b0;
      if (rx_store & fe_now)
        frm_reg <= 1'b1;
      else if (clr_frm)
        frm_reg <= 1'b0;
      if (rx_store & pe_now)
        per_reg <= 1'b1;
      else if (clr_per)
        per_reg <= 1'b0;
      if (~tx_en | (tx_last_bit_i & txe_reg))
        txend_reg <= 1'b1;
      else if (clr_txe | wr_tdr)
        txend_reg <= 1'b0;
      if (rx_store & ~sync & mp_fmt)
        rxmp_reg <= rx_mp_bit_i;
      if (wr_status)
        txmp_reg <= wbyte[`SSP_ST_TXMP];
    end
  end

  // transmit data buffer
  always @(posedge core_clk_i) begin
    if (soft_rst) begin
      tx_data_o       <= 8'h00;
      tx_data_valid_o <= 1'b0;
    end else begin
      if (wr_tdr)
        tx_data_o <= wbyte;
      tx_data_valid_o <= ~txe_reg & tx_en & ~(err_any & sync);
    end
  end

  // ------------------------------------------------------------
  // engine controls
  // ------------------------------------------------------------
  assign tx_enable_o    = tx_en & ~(err_any & sync);
  assign rx_enable_o    = rx_en & ~err_any;
  assign sync_mode_o    = sync;
  assign parity_en_o    = par_en;
  assign parity_odd_o   = par_odd;
  assign clock_source_o = {ctrl_reg[`SSP_CT_CKE_HI],
                           ctrl_reg[`SSP_CT_CKE_LO]};
  assign tx_mp_bit_o    = tx_en & ~sync & mp_fmt & txmp_reg;

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // port bits override engine on clock and transmit pins
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      txd_o    <= 1'b1;
      sck_o    <= 1'b0;
      sck_oe_o <= 1'b0;
    end else begin
      txd_o <= port_reg[`SSP_PT_BRKSEL] ?
               port_reg[`SSP_PT_BRKDAT] : tx_serial_i;
      sck_o <= port_reg[`SSP_PT_CKSEL] ?
               port_reg[`SSP_PT_CKDAT] : eng_sck_i;
      sck_oe_o <= port_reg[`SSP_PT_CKSEL] | eng_sck_oe_i;
    end
  end

  // ------------------------------------------------------------
  // bit-rate generator
  // ------------------------------------------------------------
  reg [5:0] pre_mask;

  // prescale source select
  always @* begin
    case (cks)
      2'b00:   pre_mask = `SSP_PRE_M0;
      2'b01:   pre_mask = `SSP_PRE_M1;
      2'b10:   pre_mask = `SSP_PRE_M2;
      2'b11:   pre_mask = `SSP_PRE_M3;
      default: pre_mask = `SSP_PRE_M0;
    endcase
  end

  wire pre_tick = ((pre_cnt_reg & pre_mask) == 6'h00);
  wire [4:0] bit_last = sync ? `SSP_BIT_LAST_SY : `SSP_BIT_LAST_AS;

  // prescaler, then divide by divisor+1, then per-bit divide
  always @(posedge core_clk_i) begin
    if (soft_rst) begin
      pre_cnt_reg <= 6'h00;
      brg_cnt_reg <= `SSP_BITRATE_RST;
      bit_cnt_reg <= 5'h00;
      brg_tick_o  <= 1'b0;
      bit_tick_o  <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 6'h01;
      brg_tick_o  <= 1'b0;
      bit_tick_o  <= 1'b0;
      if (pre_tick) begin
        if (brg_cnt_reg == 8'h00) begin
          brg_cnt_reg <= bitrate_reg;
          brg_tick_o  <= 1'b1;
          if (bit_cnt_reg >= bit_last) begin
            bit_cnt_reg <= 5'h00;
            bit_tick_o  <= 1'b1;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end else begin
          brg_cnt_reg <= brg_cnt_reg - 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- verif/ssp_remote_dev.sv ----
`default_nettype none
// ---------------------------------------
// remote serial device on the pins
// ---------------------------------------
module ssp_remote_dev (
  input  wire logic sck_drv_i,
  input  wire logic sck_oe_i,
  input  wire logic rx_level_i,
  input  wire logic clk_level_i,
  output wire logic rxd_o,
  output wire logic sck_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // receive pin level chosen by the bench
  assign rxd_o = rx_level_i;
  // clock pin: ours when enabled, else remote level
  assign sck_o = sck_oe_i ? sck_drv_i : clk_level_i;
endmodule
`default_nettype wire

// ---- verif/ssp_serial_status_port_baud_monitor.sv ----
`include "ssp_defines.vh"
`default_nettype none
module ssp_serial_status_port_baud_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              manual_rst_i,
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic [1:0]        s_axi_bresp_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [31:0]       s_axi_rdata_o,
  input wire logic [1:0]        s_axi_rresp_o,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_rready_i,
  input wire logic              tx_load_i,
  input wire logic              tx_data_valid_o,
  input wire logic              tx_mp_bit_o,
  input wire logic              tx_enable_o,
  input wire logic              sync_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ---------------------------------------
  // bus handshakes and flag relations
  // ---------------------------------------
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid_o)
    else $error("read data late");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  unmapped_read_a: assert property (rd_taken and s_axi_araddr_i > 8'h14
    |=> s_axi_rresp_o == `SSP_RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  write_busy_a: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while busy");
  load_empty_a: assert property (tx_load_i |-> ##[1:2] !tx_data_valid_o)
    else $error("buffer still full after load");
  reset_empty_a: assert property (manual_rst_i |=> !tx_data_valid_o)
    else $error("buffer full after reset");
  tx_off_a: assert property (!tx_enable_o ##1 !tx_enable_o |->
    !tx_data_valid_o)
    else $error("buffer full with tx off");
  mp_gate_a: assert property (tx_mp_bit_o |->
    tx_enable_o && !sync_mode_o)
    else $error("mp bit outside async tx");
endmodule
bind ssp_serial_status_port_baud ssp_serial_status_port_baud_monitor
  #(.ADDR_W(ADDR_W)) mon_u (.core_clk_i, .sys_rst_i, .manual_rst_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .tx_load_i, .tx_data_valid_o,
  .tx_mp_bit_o, .tx_enable_o, .sync_mode_o);
`default_nettype wire

// ---- verif/ssp_serial_status_port_baud_test.sv ----
`default_nettype none
module ssp_serial_status_port_baud_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 0, sys_rst_i = 1, manual_rst_i = 0;
  logic        standby_i = 0, module_standby_i = 0;
  logic [7:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0, rx_char_i = 0;
  logic [31:0] s_axi_wdata_i = 0, rd_data;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic [1:0]  rd_resp;
  logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic        tx_load_i = 0, tx_last_bit_i = 0, tx_serial_i = 1;
  logic        rx_done_i = 0, rx_parity_bit_i = 0, rx_stop_bit_i = 1;
  logic        rx_mp_bit_i = 0, eng_sck_i = 0, eng_sck_oe_i = 0;
  logic        rx_level = 0, clk_level = 1;
  wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  wire         s_axi_arready_o, s_axi_rvalid_o;
  wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o, clock_source_o;
  wire  [31:0] s_axi_rdata_o;
  wire  [7:0]  tx_data_o;
  wire         tx_data_valid_o, tx_mp_bit_o, tx_enable_o, rx_enable_o;
  wire         sync_mode_o, parity_en_o, parity_odd_o, brg_tick_o;
  wire         bit_tick_o, rxd_i, sck_i, txd_o, sck_o, sck_oe_o;
  int          err_total = 0, total_checks = 0;

  ssp_serial_status_port_baud #(.ADDR_W(8)) dut_u (.core_clk_i, .sys_rst_i,
    .manual_rst_i, .standby_i, .module_standby_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .tx_load_i, .tx_last_bit_i, .tx_serial_i, .rx_done_i, .rx_char_i,
    .rx_parity_bit_i, .rx_stop_bit_i, .rx_mp_bit_i, .eng_sck_i,
    .eng_sck_oe_i, .tx_data_o, .tx_data_valid_o, .tx_mp_bit_o, .tx_enable_o,
    .rx_enable_o, .sync_mode_o, .parity_en_o, .parity_odd_o,
    .clock_source_o, .brg_tick_o, .bit_tick_o, .rxd_i, .sck_i, .txd_o,
    .sck_o, .sck_oe_o);
  ssp_remote_dev remote_u (.sck_drv_i(sck_o), .sck_oe_i(sck_oe_o),
    .rx_level_i(rx_level), .clk_level_i(clk_level), .rxd_o(rxd_i),
    .sck_o(sck_i));

  initial forever #25 core_clk_i = ~core_clk_i;
  // ---------------------------------------
  // shared tasks
  // ---------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // axi write: both channels offered, held until each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b0;
    tb = 1'b0;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge core_clk_i);
      ta = s_axi_awvalid_i & s_axi_awready_o;
      tw = s_axi_wvalid_i & s_axi_wready_o;
      tb = s_axi_bvalid_o === 1'b1 && s_axi_bready_i;
      @(posedge core_clk_i);
      if (ta) s_axi_awvalid_i <= 1'b0;
      if (tw) s_axi_wvalid_i <= 1'b0;
      if (!tb && s_axi_bvalid_o === 1'b1) s_axi_bready_i <= 1'b1;
    end
    if (!tb) err_total++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic ta, tb;
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b0;
    tb = 1'b0;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge core_clk_i);
      ta = s_axi_arvalid_i & s_axi_arready_o;
      tb = s_axi_rvalid_o === 1'b1 && s_axi_rready_i;
      rd_data = s_axi_rdata_o;
      rd_resp = s_axi_rresp_o;
      @(posedge core_clk_i);
      if (ta) s_axi_arvalid_i <= 1'b0;
      if (!tb && s_axi_rvalid_o === 1'b1) s_axi_rready_i <= 1'b1;
    end
    if (!tb) err_total++;
    chk(rd_data, exp);
  endtask
  // one finished character from the receive engine
  task automatic rx(input logic [7:0] c, input logic p, s, m);
    rx_char_i       <= c;
    rx_parity_bit_i <= p;
    rx_stop_bit_i   <= s;
    rx_mp_bit_i     <= m;
    rx_done_i       <= 1'b1;
    @(posedge core_clk_i);
    rx_done_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // cycles between ticks, after one settling tick
  task automatic gap(input logic b, input int exp);
    int c;
    for (int k = 0; k < 2; k++)
      for (c = 1; c < 9000; c++) begin
        @(negedge core_clk_i);
        if ((b ? bit_tick_o : brg_tick_o) === 1'b1) break;
      end
    chk(c, exp);
    @(posedge core_clk_i);
  endtask
  // ---------------------------------------
  // scenarios
  // ---------------------------------------
  task automatic test_flags;
    rd(8'h00, 32'h84);
    rd(8'h04, 32'h04);
    rd(8'h08, 32'hff);
    rd(8'h18, 32'h0);
    chk(rd_resp, 2'h2);
    // transmit side
    wr(8'h0c, 32'h001);
    wr(8'h10, 32'h5a);
    rd(8'h00, 32'h00);
    chk(tx_data_o, 8'h5a);
    chk(tx_data_valid_o, 1'b1);
    tx_load_i <= 1'b1;
    @(posedge core_clk_i);
    tx_load_i <= 1'b0;
    rd(8'h00, 32'h80);
    tx_last_bit_i <= 1'b1;
    @(posedge core_clk_i);
    tx_last_bit_i <= 1'b0;
    rd(8'h00, 32'h84);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'h00);
    wr(8'h0c, 32'h000);
    rd(8'h00, 32'h84);
    // receive side, overrun and halt
    wr(8'h0c, 32'h002);
    rx(8'h3c, 1'b0, 1'b1, 1'b0);
    rd(8'h00, 32'hc4);
    rx(8'h55, 1'b0, 1'b1, 1'b0);
    rd(8'h00, 32'he4);
    rd(8'h14, 32'h3c);
    rd(8'h00, 32'ha4);
    rx(8'h66, 1'b0, 1'b1, 1'b0);
    rd(8'h00, 32'ha4);
    chk(rx_enable_o, 1'b0);
    wr(8'h0c, 32'h000);
    rd(8'h00, 32'ha4);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'h84);
    rx(8'h11, 1'b0, 1'b1, 1'b0);
    rd(8'h14, 32'h3c);
    // framing then parity errors
    wr(8'h0c, 32'h002);
    rx(8'h77, 1'b0, 1'b0, 1'b0);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'h94);
    rd(8'h14, 32'h77);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'h84);
    wr(8'h0c, 32'h012);
    rx(8'h01, 1'b0, 1'b1, 1'b0);
    rd(8'h00, 32'h8c);
    wr(8'h00, 32'h00);
    wr(8'h0c, 32'h032);
    chk({parity_odd_o, parity_en_o, rx_enable_o}, 3'h7);
    rx(8'h01, 1'b0, 1'b1, 1'b0);
    rd(8'h00, 32'hc4);
    rd(8'h14, 32'h01);
    // multiprocessor bits
    wr(8'h0c, 32'h00b);
    rx(8'h42, 1'b0, 1'b1, 1'b1);
    rd(8'h00, 32'hc6);
    wr(8'h00, 32'hc5);
    rd(8'h00, 32'hc7);
    chk(tx_mp_bit_o, 1'b1);
    wr(8'h0c, 32'h00f);
    chk(tx_mp_bit_o, 1'b0);
  endtask
  task automatic test_port;
    wr(8'h04, 32'hff);
    chk({sck_oe_o, sck_o, txd_o}, 3'h7);
    rd(8'h04, 32'h0e);
    wr(8'h04, 32'h0a);
    chk({sck_oe_o, sck_o, txd_o}, 3'h4);
    rd(8'h04, 32'h0a);
    wr(8'h04, 32'h02);
    rx_level <= 1'b1;
    rd(8'h04, 32'h07);
    chk(sck_oe_o, 1'b0);
    manual_rst_i <= 1'b1;
    @(posedge core_clk_i);
    manual_rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rd(8'h04, 32'h07);
    rd(8'h00, 32'h84);
  endtask
  task automatic test_baud;
    wr(8'h08, 32'h02);
    for (int n = 0; n < 4; n++) begin
      wr(8'h0c, 32'(n) << 6);
      gap(1'b0, 3 << (2 * n));
    end
    wr(8'h08, 32'hff);
    wr(8'h0c, 32'h300);
    chk(clock_source_o, 2'h3);
    gap(1'b0, 256);
    wr(8'h08, 32'h00);
    gap(1'b1, 32);
    wr(8'h0c, 32'h004);
    gap(1'b1, 4);
    standby_i <= 1'b1;
    @(posedge core_clk_i);
    standby_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rd(8'h08, 32'hff);
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    test_flags();
    test_port();
    test_baud();
    test_done();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
